// >>> svsq_pkg.sv
// Package: constants and carrier types for the servo control sequencer
package svsq_pkg;

    // ****************************************************
    // Timer indices and durations
    // ****************************************************
    localparam int unsigned SVSQ_NUM_TIMERS = 6;
    localparam int unsigned SVSQ_T1 = 0;
    localparam int unsigned SVSQ_T2 = 1;
    localparam int unsigned SVSQ_T3 = 2;
    localparam int unsigned SVSQ_T4 = 3;
    localparam int unsigned SVSQ_T5 = 4;
    localparam int unsigned SVSQ_T6 = 5;
    localparam int unsigned SVSQ_CNT_W = 24;
    localparam int unsigned SVSQ_CLK_NS = 8;
    localparam real SVSQ_OFFSET_MS = 5.85;
    // Offset hold in cycles, rounded down
    localparam int unsigned SVSQ_OFFSET_CYC = int'($floor(SVSQ_OFFSET_MS * 1.0e6 / SVSQ_CLK_NS));
    localparam logic [SVSQ_CNT_W-1:0] SVSQ_CNT_ONE = 24'h000001;
    localparam logic [SVSQ_CNT_W-1:0] SVSQ_CNT_ZERO = 24'h000000;
    localparam int unsigned SVSQ_FAIL_LIMIT = 2;
    localparam logic [1:0] SVSQ_FAIL_ONE = 2'h1;
    localparam logic [1:0] SVSQ_FAIL_ZERO = 2'h0;

    // ****************************************************
    // Sequencer states
    // ****************************************************
    typedef enum logic [6:0] {
        SVSQ_DISABLE  = 7'h01,
        SVSQ_TEST     = 7'h02,
        SVSQ_IDLE     = 7'h04,
        SVSQ_REVERSE  = 7'h08,
        SVSQ_FORWARD  = 7'h10,
        SVSQ_GUARD    = 7'h20,
        SVSQ_APPROACH = 7'h40
    } svsq_state_t;

    // ****************************************************
    // Carrier structs
    // ****************************************************
    typedef struct packed {
        logic seek_permit;
        logic head_load_start;
        logic plug_replaced;
        logic rezero_start;
        logic servo_error;
        logic slow_speed_detect;
        logic diff_count_zero;
        logic near_center;
        logic servo_data;
        logic offset_begin;
        logic heads_extended;
    } svsq_in_t;

    typedef struct packed {
        logic servo_logic_on;
        logic recal_request;
        logic vel_mode_on;
        logic carriage_stopped;
        logic position_mode;
        logic power_amp_on;
        logic settle_delay_start;
        logic ready;
        logic final_approach;
        logic move_reverse;
        logic slow_program_speed;
        logic guard_zone;
        logic seek_failed;
        logic retract;
    } svsq_out_t;

endpackage : svsq_pkg

// >>> svsq_one_shot.sv
// Retriggerable one-shot timer
`timescale 1ns/10ps
`default_nettype none
module svsq_one_shot #(
    parameter logic [svsq_pkg::SVSQ_CNT_W-1:0] DURATION = 24'h000100
) (
    input  wire logic ref_clk_i,     // Clock
    input  wire logic rst_n_i,       // Sync reset, active low
    input  wire logic trig_i,        // Trigger level
    input  wire logic clear_i,       // Force expiry off
    output logic      running_o,     // Interval in progress
    output logic      expired_o      // One-cycle expiry pulse
);
    import svsq_pkg::*;

    logic [SVSQ_CNT_W-1:0] cnt_ff;
    logic [SVSQ_CNT_W-1:0] nxt_cnt;
    logic                  trig_ff;
    logic                  exp_ff;
    logic                  nxt_exp;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_exp = 1'b0;
        if (clear_i) begin
            nxt_cnt = SVSQ_CNT_ZERO;
        // RULE1 rising edge restarts
        end else if (trig_i && !trig_ff) begin
            nxt_cnt = DURATION;
        end else if (cnt_ff != SVSQ_CNT_ZERO) begin
            nxt_cnt = cnt_ff - SVSQ_CNT_ONE;
            nxt_exp = (cnt_ff == SVSQ_CNT_ONE);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_ff  <= SVSQ_CNT_ZERO;
            trig_ff <= 1'b0;
            exp_ff  <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            trig_ff <= trig_i;
            exp_ff  <= nxt_exp;
        end
    end

    assign running_o = (cnt_ff != SVSQ_CNT_ZERO);
    assign expired_o = exp_ff;
endmodule // svsq_one_shot
`default_nettype wire

// >>> svsq_servo_sequencer.sv
// Servo control sequencer top level
//
// Contract
// RULE1: Six retriggerable one-shots pace states; rising trigger restarts interval.
// RULE2: Servo logic on latches with seek permit after timers two, six tested.
// RULE3: Permit drop forces disable; raise enters test running timers one, two, six.
// RULE4: Recalibrate request latches on head load, plug replace, rezero, servo error.
// RULE5: Recalibrate enables power amp, velocity control, seeks track zero.
// RULE6: Request starts timers one, two; velocity mode latches when six starts.
// RULE7: Velocity mode allowed with heads retracted or extended.
// RULE8: Carriage stopped latches on slow speed unless timer three or four.
// RULE9: Carriage stopped triggers timer one; its expiry means position mode.
// RULE10: Power amp latches on timer one expiry unless held reset.
// RULE11: Settle delay starts near center, amp on, not already ready.
// RULE12: Ready latches on timer five expiry if six running, no reset.
// RULE13: Offset begin drops ready for 5.85 ms via timer four.
// RULE14: Velocity seeking only allowed while ready.
// RULE15: Final approach only before timer six expiry, velocity on, count zero.
// RULE16: Rezero with servo data drives reverse at slow program speed.
// RULE17: Then forward until servo data; timer four delays guard zone entry (code enters guard at once and leaves it when timer four ends).
// RULE18: Guard zone starts six, resets two; then final approach on zero count.
// RULE19: Seek failed if two expires before six starts, or six before ready.
// RULE20: Two consecutive seek failures retract the heads.
// RULE21: Timer durations are build-time parameters in clock cycles.
`timescale 1ns/10ps
`default_nettype none
module svsq_servo_sequencer #(
    // RULE21 build-time durations
    parameter logic [svsq_pkg::SVSQ_CNT_W-1:0] T1_CYC = 24'h000400,
    parameter logic [svsq_pkg::SVSQ_CNT_W-1:0] T2_CYC = 24'h004000,
    parameter logic [svsq_pkg::SVSQ_CNT_W-1:0] T3_CYC = 24'h000400,
    parameter logic [svsq_pkg::SVSQ_CNT_W-1:0] T4_CYC = svsq_pkg::SVSQ_CNT_W'(svsq_pkg::SVSQ_OFFSET_CYC),
    parameter logic [svsq_pkg::SVSQ_CNT_W-1:0] T5_CYC = 24'h000800,
    parameter logic [svsq_pkg::SVSQ_CNT_W-1:0] T6_CYC = 24'h008000
) (
    input  wire logic          ref_clk_i,  // Clock, 125 MHz
    input  wire logic          rst_n_i,    // Sync reset, active low
    input  wire svsq_pkg::svsq_in_t  stat_i, // Status and command inputs
    output var  svsq_pkg::svsq_out_t ctl_o   // Control and status outputs
);
    import svsq_pkg::*;

    // ****************************************************
    // Timers
    // ****************************************************
    localparam logic [SVSQ_NUM_TIMERS*SVSQ_CNT_W-1:0] DURS = {T6_CYC, T5_CYC, T4_CYC, T3_CYC, T2_CYC, T1_CYC};

    logic [SVSQ_NUM_TIMERS-1:0] trig;
    logic [SVSQ_NUM_TIMERS-1:0] clr;
    logic [SVSQ_NUM_TIMERS-1:0] run;
    logic [SVSQ_NUM_TIMERS-1:0] exp;

    // RULE1 six one-shots
    genvar g;
    generate
        for (g = 0; g < SVSQ_NUM_TIMERS; g++) begin : g_tmr
            svsq_one_shot #(
                .DURATION (DURS[g*SVSQ_CNT_W +: SVSQ_CNT_W])
            ) u_tmr (
                .ref_clk_i (ref_clk_i),
                .rst_n_i   (rst_n_i),
                .trig_i    (trig[g]),
                .clear_i   (clr[g]),
                .running_o (run[g]),
                .expired_o (exp[g])
            );
        end
    endgenerate

    // ****************************************************
    // State registers
    // ****************************************************
    svsq_state_t state_ff;
    svsq_state_t nxt_state;
    logic        on_ff;
    logic        nxt_on;
    logic        t2_ok_ff;
    logic        nxt_t2_ok;
    logic        t6_ok_ff;
    logic        nxt_t6_ok;
    logic        recal_ff;
    logic        nxt_recal;
    logic        vel_latch_ff;
    logic        nxt_vel_latch;
    logic        vel_ff;
    logic        nxt_vel;
    logic        stop_ff;
    logic        nxt_stop;
    logic        pos_ff;
    logic        nxt_pos;
    logic        amp_ff;
    logic        nxt_amp;
    logic        settle_ff;
    logic        nxt_settle;
    logic        rdy_ff;
    logic        nxt_rdy;
    logic        fail_ff;
    logic        nxt_fail;
    logic [1:0]  fail_cnt_ff;
    logic [1:0]  nxt_fail_cnt;
    logic        retract_ff;
    logic        nxt_retract;
    logic        permit_ff;
    logic        rdy_reset;
    logic        fail_evt;
    logic        final_app;
    logic        tst_trig;
    logic        recal_trig;

    // Low once test passes, so the recal edge restarts timers
    assign tst_trig   = (state_ff == SVSQ_TEST) && !(t2_ok_ff && t6_ok_ff);
    assign recal_trig = recal_ff && (state_ff == SVSQ_IDLE);

    // RULE12 five ready reset conditions
    assign rdy_reset = !on_ff || stat_i.offset_begin || run[SVSQ_T4] || recal_ff || fail_evt;

    // RULE19 incomplete seek detection
    assign fail_evt = on_ff && ((exp[SVSQ_T2] && !run[SVSQ_T6] && vel_ff)
                             || (exp[SVSQ_T6] && !rdy_ff));

    // RULE15 final approach window
    assign final_app = on_ff && vel_ff && stat_i.diff_count_zero && run[SVSQ_T6];

    // ****************************************************
    // Timer triggers
    // ****************************************************
    always_comb begin
        trig = '0;
        clr  = '0;
        // RULE3 test starts one, two, six
        // RULE6 request starts one, two
        // RULE9 stop triggers one
        trig[SVSQ_T1] = tst_trig || recal_trig || stop_ff;
        trig[SVSQ_T2] = tst_trig || recal_trig;
        trig[SVSQ_T3] = vel_ff && !stop_ff;
        // RULE13 offset hold
        // RULE17 guard delay
        trig[SVSQ_T4] = stat_i.offset_begin || (state_ff == SVSQ_FORWARD && stat_i.servo_data);
        // RULE11 settle interval
        trig[SVSQ_T5] = settle_ff;
        // RULE18 guard starts six
        // RULE6 recal also starts six
        trig[SVSQ_T6] = tst_trig || recal_trig || (state_ff == SVSQ_GUARD);
        // RULE18 guard resets two
        clr[SVSQ_T2] = (state_ff == SVSQ_GUARD);
    end

    // ****************************************************
    // Sequencer next state
    // ****************************************************
    always_comb begin
        nxt_state     = state_ff;
        nxt_on        = on_ff;
        nxt_t2_ok     = t2_ok_ff;
        nxt_t6_ok     = t6_ok_ff;
        nxt_recal     = recal_ff;
        nxt_vel_latch = vel_latch_ff;
        nxt_vel       = vel_ff;
        nxt_stop      = stop_ff;
        nxt_pos       = pos_ff;
        nxt_amp       = amp_ff;
        nxt_settle    = 1'b0;
        nxt_rdy       = rdy_ff;
        nxt_fail      = 1'b0;
        nxt_fail_cnt  = fail_cnt_ff;
        nxt_retract   = retract_ff;
        case (state_ff)
            SVSQ_DISABLE: begin
                // RULE3 raise enters test
                if (stat_i.seek_permit && !permit_ff) begin
                    nxt_state = SVSQ_TEST;
                    nxt_t2_ok = 1'b0;
                    nxt_t6_ok = 1'b0;
                end
            end
            SVSQ_TEST: begin
                if (exp[SVSQ_T2]) begin
                    nxt_t2_ok = 1'b1;
                end
                if (exp[SVSQ_T6]) begin
                    nxt_t6_ok = 1'b1;
                end
                // RULE2 latch servo logic on
                if (t2_ok_ff && t6_ok_ff) begin
                    nxt_on    = 1'b1;
                    nxt_recal = 1'b1;
                    nxt_state = SVSQ_IDLE;
                end
            end
            SVSQ_IDLE: begin
                // RULE5 recalibrate sequence
                // RULE7 any head position
                if (recal_ff) begin
                    nxt_vel_latch = 1'b1;
                    nxt_stop      = 1'b0;
                    nxt_pos       = 1'b0;
                    nxt_amp       = 1'b1;
                    nxt_state     = stat_i.servo_data ? SVSQ_REVERSE : SVSQ_FORWARD;
                // RULE14 seek only while ready
                end else if (rdy_ff && !stat_i.diff_count_zero) begin
                    nxt_vel_latch = 1'b1;
                    nxt_stop      = 1'b0;
                    nxt_pos       = 1'b0;
                    nxt_rdy       = 1'b0;
                    nxt_state     = SVSQ_GUARD;
                end
            end
            SVSQ_REVERSE: begin
                // RULE16 reverse until servo data lost
                if (!stat_i.servo_data) begin
                    nxt_state = SVSQ_FORWARD;
                end
            end
            SVSQ_FORWARD: begin
                // RULE17 forward until servo data
                if (stat_i.servo_data) begin
                    nxt_state = SVSQ_GUARD;
                end
            end
            SVSQ_GUARD: begin
                if (!run[SVSQ_T4]) begin
                    nxt_recal = 1'b0;
                    nxt_state = SVSQ_APPROACH;
                end
            end
            SVSQ_APPROACH: begin
                if (rdy_ff) begin
                    nxt_state = SVSQ_IDLE;
                end
            end
            default: begin
                nxt_state = SVSQ_DISABLE;
            end
        endcase

        // RULE6 velocity mode latch
        if (vel_latch_ff && run[SVSQ_T6] && !stat_i.diff_count_zero && !stop_ff) begin
            nxt_vel = 1'b1;
        end
        // RULE8 stop on slow speed
        if (vel_ff && stat_i.slow_speed_detect && !run[SVSQ_T3] && !run[SVSQ_T4]) begin
            nxt_stop      = 1'b1;
            nxt_vel       = 1'b0;
            nxt_vel_latch = 1'b0;
        end
        // RULE9 position mode on expiry
        if (stop_ff && exp[SVSQ_T1]) begin
            nxt_pos = 1'b1;
        end
        // RULE10 amp latch
        if (exp[SVSQ_T1] && on_ff) begin
            nxt_amp = 1'b1;
        end
        // RULE11 settle start
        if (stat_i.near_center && amp_ff && !rdy_ff && pos_ff && !run[SVSQ_T5] && !settle_ff) begin
            nxt_settle = 1'b1;
        end
        // RULE12 ready latch
        if (exp[SVSQ_T5] && run[SVSQ_T6] && !rdy_reset) begin
            nxt_rdy = 1'b1;
        end
        // RULE13 offset drops ready
        if (stat_i.offset_begin || run[SVSQ_T4]) begin
            nxt_rdy = 1'b0;
        end
        if (nxt_rdy) begin
            nxt_fail_cnt = SVSQ_FAIL_ZERO;
        end
        // RULE19 failure flag
        // RULE20 consecutive failures retract
        if (fail_evt) begin
            nxt_fail  = 1'b1;
            nxt_rdy   = 1'b0;
            nxt_recal = 1'b1;
            nxt_vel   = 1'b0;
            nxt_state = SVSQ_IDLE;
            if (fail_cnt_ff == 2'(SVSQ_FAIL_LIMIT - 1)) begin
                nxt_retract = 1'b1;
                nxt_amp     = 1'b0;
            end else begin
                nxt_fail_cnt = fail_cnt_ff + SVSQ_FAIL_ONE;
            end
        end
        // RULE4 recalibrate request sources
        if (on_ff && (stat_i.head_load_start || stat_i.plug_replaced
                   || stat_i.rezero_start || stat_i.servo_error)) begin
            nxt_recal = 1'b1;
        end
        // RULE2 nothing runs without servo logic on
        // RULE3 permit drop forces disable
        if (!stat_i.seek_permit) begin
            nxt_state     = SVSQ_DISABLE;
            nxt_on        = 1'b0;
            nxt_recal     = 1'b0;
            nxt_vel_latch = 1'b0;
            nxt_vel       = 1'b0;
            nxt_stop      = 1'b0;
            nxt_pos       = 1'b0;
            nxt_amp       = 1'b0;
            nxt_settle    = 1'b0;
            nxt_rdy       = 1'b0;
            nxt_fail      = 1'b0;
            nxt_fail_cnt  = SVSQ_FAIL_ZERO;
            nxt_retract   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_ff     <= SVSQ_DISABLE;
            on_ff        <= 1'b0;
            t2_ok_ff     <= 1'b0;
            t6_ok_ff     <= 1'b0;
            recal_ff     <= 1'b0;
            vel_latch_ff <= 1'b0;
            vel_ff       <= 1'b0;
            stop_ff      <= 1'b0;
            pos_ff       <= 1'b0;
            amp_ff       <= 1'b0;
            settle_ff    <= 1'b0;
            rdy_ff       <= 1'b0;
            fail_ff      <= 1'b0;
            fail_cnt_ff  <= SVSQ_FAIL_ZERO;
            retract_ff   <= 1'b0;
            permit_ff    <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            on_ff        <= nxt_on;
            t2_ok_ff     <= nxt_t2_ok;
            t6_ok_ff     <= nxt_t6_ok;
            recal_ff     <= nxt_recal;
            vel_latch_ff <= nxt_vel_latch;
            vel_ff       <= nxt_vel;
            stop_ff      <= nxt_stop;
            pos_ff       <= nxt_pos;
            amp_ff       <= nxt_amp;
            settle_ff    <= nxt_settle;
            rdy_ff       <= nxt_rdy;
            fail_ff      <= nxt_fail;
            fail_cnt_ff  <= nxt_fail_cnt;
            retract_ff   <= nxt_retract;
            permit_ff    <= stat_i.seek_permit;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign ctl_o.servo_logic_on     = on_ff;
    assign ctl_o.recal_request      = recal_ff;
    assign ctl_o.vel_mode_on        = vel_ff;
    assign ctl_o.carriage_stopped   = stop_ff;
    assign ctl_o.position_mode      = pos_ff;
    assign ctl_o.power_amp_on       = amp_ff;
    assign ctl_o.settle_delay_start = settle_ff;
    assign ctl_o.ready              = rdy_ff;
    assign ctl_o.final_approach     = final_app;
    // RULE16 reverse at slow speed
    assign ctl_o.move_reverse       = (state_ff == SVSQ_REVERSE) && vel_ff;
    assign ctl_o.slow_program_speed = ((state_ff == SVSQ_REVERSE) || (state_ff == SVSQ_FORWARD)) && vel_ff;
    assign ctl_o.guard_zone         = (state_ff == SVSQ_GUARD);
    assign ctl_o.seek_failed        = fail_ff;
    assign ctl_o.retract            = retract_ff;
endmodule // svsq_servo_sequencer
`default_nettype wire

// >>> svsq_servo_sequencer_checker.sv
// Assertion checker for the servo control sequencer
`timescale 1ns/10ps
`default_nettype none
module svsq_servo_sequencer_checker
    import svsq_pkg::*;
#(
    parameter logic [SVSQ_CNT_W-1:0] T6_CYC = 24'h008000
) (
    input wire logic                ref_clk_i, // Clock
    input wire logic                rst_n_i,   // Sync reset, active low
    input wire svsq_pkg::svsq_in_t  stat_i,    // Sequencer inputs
    input wire svsq_pkg::svsq_out_t ctl_o      // Sequencer outputs
);
    // ****************************************************
    // Cycles since permit rose
    // ****************************************************
    logic [SVSQ_CNT_W-1:0] wait_ff;
    logic [SVSQ_CNT_W-1:0] nxt_wait;
    always_comb begin
        nxt_wait = wait_ff;
        if (!stat_i.seek_permit) begin
            nxt_wait = SVSQ_CNT_ZERO;
        end else if (wait_ff != '1) begin
            nxt_wait = wait_ff + SVSQ_CNT_ONE;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wait_ff <= SVSQ_CNT_ZERO;
        end else begin
            wait_ff <= nxt_wait;
        end
    end
    // ****************************************************
    // Properties
    // ****************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_ready_low;
        !ctl_o.ready [*8];
    endsequence
    property p_perm;
        !stat_i.seek_permit |=> ctl_o == '0;
    endproperty
    property p_gate;
        !ctl_o.servo_logic_on |-> !(ctl_o.vel_mode_on || ctl_o.power_amp_on || ctl_o.ready);
    endproperty
    property p_on;
        $rose(ctl_o.servo_logic_on) |-> wait_ff >= T6_CYC;
    endproperty
    property p_fa;
        ctl_o.final_approach |-> stat_i.diff_count_zero && ctl_o.servo_logic_on;
    endproperty
    property p_rev;
        ctl_o.move_reverse |-> ctl_o.slow_program_speed;
    endproperty
    property p_stop;
        $rose(ctl_o.carriage_stopped) |-> $past(stat_i.slow_speed_detect);
    endproperty
    property p_settle;
        ctl_o.settle_delay_start |-> $past(ctl_o.power_amp_on) && !$past(ctl_o.ready)
            && $past(stat_i.near_center) ##1 !ctl_o.settle_delay_start;
    endproperty
    property p_fail;
        ctl_o.seek_failed |=> !ctl_o.seek_failed;
    endproperty
    property p_offset;
        $rose(stat_i.offset_begin) |=> s_ready_low;
    endproperty
    property p_retract;
        ctl_o.retract && stat_i.seek_permit |=> ctl_o.retract;
    endproperty
    a_perm: assert property (p_perm) else $error("outputs not cleared");
    a_gate: assert property (p_gate) else $error("segment active while off");
    a_on: assert property (p_on) else $error("servo logic on too early");
    a_fa: assert property (p_fa) else $error("bad final approach");
    a_rev: assert property (p_rev) else $error("reverse without slow speed");
    a_stop: assert property (p_stop) else $error("stop without slow speed");
    a_settle: assert property (p_settle) else $error("bad settle start");
    a_fail: assert property (p_fail) else $error("failure pulse too long");
    a_offset: assert property (p_offset) else $error("ready during offset");
    a_retract: assert property (p_retract) else $error("retract dropped");
endmodule // svsq_servo_sequencer_checker
bind svsq_servo_sequencer svsq_servo_sequencer_checker #(.T6_CYC(T6_CYC)) u_chk (
    .ref_clk_i(ref_clk_i),
    .rst_n_i  (rst_n_i),
    .stat_i   (stat_i),
    .ctl_o    (ctl_o)
);
`default_nettype wire

// >>> svsq_carriage_model.sv
// Behavioural carriage and head model on the sequencer's far side
`timescale 1ns/10ps
`default_nettype none
module svsq_carriage_model
    import svsq_pkg::*;
(
    input  wire logic                ref_clk_i, // Clock
    input  wire logic                rst_n_i,   // Sync reset, active low
    input  wire svsq_pkg::svsq_out_t ctl_i,     // Sequencer outputs
    input  wire logic                stall_i,   // Never find servo data
    output logic                     sd_o,      // Servo data seen
    output logic                     ss_o,      // Slow speed
    output logic                     nc_o       // Near track center
);
    logic [2:0] run_ff;
    logic       sd_ff;
    logic       ss_ff;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !ctl_i.servo_logic_on) begin
            sd_ff  <= 1'b1;
            ss_ff  <= 1'b0;
            run_ff <= 3'h0;
        end else begin
            ss_ff <= ctl_i.final_approach | (ss_ff & ctl_i.vel_mode_on);
            if (ctl_i.move_reverse || (ctl_i.slow_program_speed && !stall_i)) begin
                run_ff <= run_ff + 3'h1;
                if (run_ff == 3'h5) begin
                    sd_ff  <= !ctl_i.move_reverse;
                    run_ff <= 3'h0;
                end
            end else begin
                run_ff <= 3'h0;
            end
        end
    end
    assign sd_o = sd_ff;
    assign ss_o = ss_ff;
    assign nc_o = ctl_i.position_mode;
endmodule // svsq_carriage_model
`default_nettype wire

// >>> svsq_servo_sequencer_tb_top.sv
// Self-checking testbench for the servo control sequencer
`timescale 1ns/10ps
`default_nettype none
module svsq_servo_sequencer_tb_top;
    import svsq_pkg::*;
    localparam logic [SVSQ_CNT_W-1:0] T2C = 24'h0000c8;
    localparam logic [SVSQ_CNT_W-1:0] T6C = 24'h000190;
    logic      ref_clk_i;
    logic      rst_n_i;
    logic      stall;
    logic      sd;
    logic      ss;
    logic      nc;
    svsq_in_t  drv;
    svsq_in_t  stat;
    svsq_out_t ctl;
    int        error_cnt;
    int        checks;
    always_comb begin
        stat                   = drv;
        stat.servo_data        = sd;
        stat.slow_speed_detect = ss;
        stat.near_center       = nc;
    end
    svsq_servo_sequencer #(
        .T1_CYC(24'h000008), .T2_CYC(T2C), .T3_CYC(24'h000004),
        .T4_CYC(24'h00000a), .T5_CYC(24'h000008), .T6_CYC(T6C)
    ) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .stat_i(stat), .ctl_o(ctl));
    svsq_carriage_model u_car (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ctl_i(ctl),
        .stall_i(stall), .sd_o(sd), .ss_o(ss), .nc_o(nc));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask
    task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_bit(input string nm, input int b, input int lim);
        int i;
        for (i = 0; i < lim && ctl[b] !== 1'b1; i++) tick(1);
        chk(nm, 14'(ctl[b]), 14'h0001);
        if (ctl[b] !== 1'b1) give_verdict();
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    // timer test
    task automatic t_power;
        chk("ctl after reset", ctl, 14'h0000);
        @(posedge ref_clk_i) drv.seek_permit <= 1'b1;
        tick(int'(T2C));
        chk("on early", 14'(ctl.servo_logic_on), 14'h0000);
        wait_bit("servo on", 13, int'(T6C));
        chk("recal", 14'(ctl.recal_request), 14'h0001);
    endtask
    task automatic t_rezero;
        wait_bit("reverse", 4, 50);
        chk("slow prog", 14'(ctl.slow_program_speed), 14'h0001);
        wait_bit("guard", 2, 100);
        wait_bit("vel mode", 11, 50);
        @(posedge ref_clk_i) drv.diff_count_zero <= 1'b1;
        wait_bit("approach", 5, 50);
        wait_bit("stopped", 10, 50);
        wait_bit("position", 9, 50);
        wait_bit("amp", 8, 5);
        wait_bit("ready", 6, 100);
        chk("recal done", 14'(ctl.recal_request), 14'h0000);
    endtask
    task automatic t_offset;
        @(posedge ref_clk_i) drv.offset_begin <= 1'b1;
        @(posedge ref_clk_i) drv.offset_begin <= 1'b0;
        tick(6);
        chk("ready in offset", 14'(ctl.ready), 14'h0000);
        wait_bit("ready again", 6, 100);
    endtask
    task automatic t_seek;
        @(posedge ref_clk_i) drv.diff_count_zero <= 1'b0;
        wait_bit("seek guard", 2, 20);
        chk("ready in seek", 14'(ctl.ready), 14'h0000);
        chk("recal idle", 14'(ctl.recal_request), 14'h0000);
        @(posedge ref_clk_i) drv.servo_error <= 1'b1;
        @(posedge ref_clk_i) drv.servo_error <= 1'b0;
        wait_bit("recal on err", 12, 5);
        @(posedge ref_clk_i) drv.seek_permit <= 1'b0;
        tick(1);
        chk("ctl after drop", ctl, 14'h0000);
    endtask
    task automatic t_fail;
        @(posedge ref_clk_i) stall <= 1'b1;
        @(posedge ref_clk_i) drv.seek_permit <= 1'b1;
        wait_bit("servo on 2", 13, int'(T6C) + 50);
        wait_bit("failed", 1, 600);
        chk("retract early", 14'(ctl.retract), 14'h0000);
        @(posedge ref_clk_i) drv.servo_error <= 1'b1;
        @(posedge ref_clk_i) drv.servo_error <= 1'b0;
        wait_bit("recal err", 12, 5);
        wait_bit("failed 2", 1, 600);
        wait_bit("retract", 0, 5);
        chk("amp off", 14'(ctl.power_amp_on), 14'h0000);
    endtask
    initial begin
        rst_n_i   = 1'b0;
        drv       = '0;
        stall     = 1'b0;
        error_cnt = 0;
        checks    = 0;
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        tick(2);
        t_power();
        t_rezero();
        t_offset();
        t_seek();
        t_fail();
        give_verdict();
    end
endmodule // svsq_servo_sequencer_tb_top
`default_nettype wire
